// ### logic/decode_pkg.sv
// constants, types and shared decode helpers for the decode throttle
`default_nettype none
package decode_pkg;

    // ------------------------------------------------------------
    // per-cycle decode limits
    // ------------------------------------------------------------
    localparam int          LEN_W                 = 4;
    localparam int          PFX_W                 = 4;
    localparam logic [3:0]  LONG_INST_BYTES       = 4'h8;  // longest multi-decode
    localparam logic [4:0]  BYTES_PER_CYCLE       = 5'h10; // byte budget
    localparam logic [3:0]  PREFIX_LIMIT          = 4'h3;  // prefix/escape
    localparam logic [1:0]  PREFIX_PENALTY_CYCLES = 2'h3;  // stall cycles
    localparam logic [1:0]  BRANCHES_PER_CYCLE    = 2'h1;
    localparam int          LANES                 = 2;     // decoder slots

    // ------------------------------------------------------------
    // reset values and field layout of the micro-op word
    // ------------------------------------------------------------
    localparam logic [1:0]  STEP_RESET            = 2'h0;
    localparam int          UOP_W                 = 7;
    localparam int          UOP_KIND_LSB          = 3;
    localparam int          UOP_SLOT_BIT          = 2;
    localparam int          UOP_ROM_BIT           = 1;
    localparam int          UOP_LAST_BIT          = 0;

    // instruction classes as marked by the fetch unit
    typedef enum logic [2:0] {
        CLS_SIMPLE,
        CLS_INC_DEC,
        CLS_CALL_MEM,
        CLS_PUSH_MEM,
        CLS_MUL_WIDE,
        CLS_MUL_TWO
    } inst_class_type;

    // micro-op kinds handed to the backend
    typedef enum logic [3:0] {
        UOP_ALU,
        UOP_FLAG_MERGE,
        UOP_LOAD,
        UOP_STORE,
        UOP_STACK_ADJUST,
        UOP_BRANCH,
        UOP_MUL_LOW,
        UOP_MUL_HIGH,
        UOP_MULTIPLY
    } uop_kind_type;

    // classes expanded by the microcode sequence rom
    function automatic logic uses_rom(input inst_class_type cls);
        return (cls == CLS_CALL_MEM) || (cls == CLS_PUSH_MEM) ||
               (cls == CLS_MUL_WIDE);
    endfunction

endpackage
`default_nettype wire

// ### logic/uop_skid_buffer.sv
// two-entry micro-op buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uop_skid_buffer #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic             spare_valid;
    logic [WIDTH-1:0] spare_data;

    // ------------------------------------------------------------
    // head feeds the port straight from flops; spare catches the
    // word that arrives in the cycle the drain stalls
    // ------------------------------------------------------------
    assign in_ready = ~spare_valid;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            out_valid   <= 1'b0;
            spare_valid <= 1'b0;
        end else if (out_ready || !out_valid) begin
            if (spare_valid) begin
                out_valid   <= 1'b1;
                spare_valid <= 1'b0;
            end else begin
                out_valid <= in_valid;
            end
        end else if (in_valid && !spare_valid) begin
            spare_valid <= 1'b1;
        end
    end

    // data registers need no reset, validity guards them
    always_ff @(posedge sys_clk) begin
        if (out_ready || !out_valid) begin
            out_data <= spare_valid ? spare_data : in_data;
        end
        if (!spare_valid && in_valid && out_valid && !out_ready) begin
            spare_data <= in_data;
        end
    end

endmodule
`default_nettype wire

// ### logic/microcode_sequence_rom.sv
// microcode sequence rom: flows of micro-ops for complex instructions
`timescale 1ns/1ps
`default_nettype none
module microcode_sequence_rom
    import decode_pkg::*;
(
    // lookup
    input  wire logic [2:0] cls,
    input  wire logic [1:0] step,
    // flow entry
    output logic [3:0]      kind,
    output logic            last
);

    // ------------------------------------------------------------
    // constant flow table, one entry per class and step
    // ------------------------------------------------------------
    always_comb begin
        kind = UOP_ALU;
        last = 1'b1;
        case (inst_class_type'(cls))
            CLS_CALL_MEM: begin
                // load target, push return, adjust stack, jump
                last = (step == 2'h3);
                case (step)
                    2'h0:    kind = UOP_LOAD;
                    2'h1:    kind = UOP_STORE;
                    2'h2:    kind = UOP_STACK_ADJUST;
                    default: kind = UOP_BRANCH;
                endcase
            end
            CLS_PUSH_MEM: begin
                last = (step == 2'h2);
                case (step)
                    2'h0:    kind = UOP_LOAD;
                    2'h1:    kind = UOP_STORE;
                    default: kind = UOP_STACK_ADJUST;
                endcase
            end
            CLS_MUL_WIDE: begin
                // double-width result written as two halves
                last = (step == 2'h1);
                kind = (step == 2'h0) ? UOP_MUL_LOW : UOP_MUL_HIGH;
            end
            default: begin
                kind = UOP_ALU;
                last = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### logic/instruction_decode_throttle.sv
// front-end decode stage with per-cycle throttling and micro-op output
//
// Operation
// - a decode cycle takes at most 16 bytes when each instruction is 8 or less.
// - an instruction longer than 8 bytes decodes alone, in slot zero only.
// - more than 3 prefix and escape bytes adds a 3-cycle stall before its uops.
// - an instruction over the prefix limit decodes only in slot zero.
// - at most one branch is decoded per cycle; a further one waits.
// - complex instructions expand into multi-uop flows from the microcode rom.
// - memory-operand near indirect calls and pushes go through the rom.
// - single-operand wide multiplies use the rom; two-operand ones do not.
// - increment and decrement emit one extra flag-merge uop.
`timescale 1ns/1ps
`default_nettype none
module instruction_decode_throttle
    import decode_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // fetch packet, lane 0 is the older instruction
    input  wire logic       fetch_valid,
    output logic            fetch_ready,
    input  wire logic       lane1_valid,
    input  wire logic [3:0] inst0_length,
    input  wire logic [3:0] inst0_prefixes,
    input  wire logic       inst0_branch,
    input  wire logic [2:0] inst0_class,
    input  wire logic [3:0] inst1_length,
    input  wire logic [3:0] inst1_prefixes,
    input  wire logic       inst1_branch,
    input  wire logic [2:0] inst1_class,
    // micro-op stream to the backend
    output logic            uop_valid,
    input  wire logic       uop_ready,
    output logic [3:0]      uop_kind,
    output logic            uop_slot,
    output logic            uop_rom,
    output logic            uop_last,
    // status
    output logic            penalty_active,
    output logic            solo_decode
);

    // ------------------------------------------------------------
    // state and held packet
    // ------------------------------------------------------------
    typedef enum {
        ST_EMPTY,
        ST_GROUP,
        ST_PENALTY,
        ST_EMIT
    } state_type;

    state_type        state;
    state_type        next_state;
    logic [3:0]       hold_len   [LANES];
    logic [3:0]       hold_pfx   [LANES];
    logic             hold_br    [LANES];
    inst_class_type   hold_cls   [LANES];
    logic [LANES-1:0] hold_pend;
    logic [LANES-1:0] grp_mask;
    logic             emit_lane;
    logic             emit_slot;
    logic [1:0]       step;
    logic [1:0]       pen_cnt;

    // group decision, looked at only in ST_GROUP
    logic             first_lane;
    logic             first_solo;
    logic             first_heavy;
    logic             join_second;
    logic [4:0]       pair_bytes;
    logic [1:0]       pair_branches;

    // current uop
    inst_class_type   cur_cls;
    logic [3:0]       hw_kind;
    logic             hw_last;
    logic [3:0]       rom_kind;
    logic             rom_last;
    logic             cur_rom;
    logic [3:0]       cur_kind;
    logic             cur_last;
    logic             push;
    logic             buf_in_ready;
    logic [UOP_W-1:0] buf_in_data;
    logic [UOP_W-1:0] buf_out_data;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic too_long(input logic [3:0] len);
        return len > LONG_INST_BYTES;
    endfunction

    function automatic logic too_many_prefixes(input logic [3:0] pfx);
        return pfx > PREFIX_LIMIT;
    endfunction

    // direct-path flows for instructions the hardware decoders handle
    function automatic logic [4:0] hw_flow(input inst_class_type cls,
                                           input logic           br,
                                           input logic [1:0]     stp);
        logic [3:0] k;
        logic       l;
        k = br ? UOP_BRANCH : UOP_ALU;
        l = 1'b1;
        if (cls == CLS_INC_DEC) begin
            k = (stp == STEP_RESET) ? UOP_ALU : UOP_FLAG_MERGE;
            l = (stp != STEP_RESET);
        end else if (cls == CLS_MUL_TWO) begin
            k = UOP_MULTIPLY;
        end
        return {k, l};
    endfunction

    // ------------------------------------------------------------
    // group formation over the pending lanes of the held packet
    // ------------------------------------------------------------
    always_comb begin
        first_lane    = ~hold_pend[0];
        first_heavy   = too_many_prefixes(hold_pfx[first_lane]);
        first_solo    = too_long(hold_len[first_lane]) || first_heavy;
        pair_bytes    = {1'b0, hold_len[0]} + {1'b0, hold_len[1]};
        pair_branches = {1'b0, hold_br[0]} + {1'b0, hold_br[1]};
        // a long or prefix-heavy instruction never rides in slot one
        join_second   = hold_pend[0] && hold_pend[1] && !first_solo &&
                        !too_long(hold_len[1]) &&
                        !too_many_prefixes(hold_pfx[1]) &&
                        (pair_bytes <= BYTES_PER_CYCLE) &&
                        (pair_branches <= BRANCHES_PER_CYCLE);
    end

    // ------------------------------------------------------------
    // uop selection: rom flow or direct decode
    // ------------------------------------------------------------
    assign cur_cls = hold_cls[emit_lane];
    assign cur_rom = uses_rom(cur_cls);

    microcode_sequence_rom u_rom (
        .cls  (cur_cls),
        .step (step),
        .kind (rom_kind),
        .last (rom_last)
    );

    assign {hw_kind, hw_last} = hw_flow(cur_cls, hold_br[emit_lane], step);
    assign cur_kind = cur_rom ? rom_kind : hw_kind;
    assign cur_last = cur_rom ? rom_last : hw_last;

    // a uop leaves only when the buffer has room, so a stall loses none
    assign push        = (state == ST_EMIT) && buf_in_ready;
    assign buf_in_data = {cur_kind, emit_slot, cur_rom, cur_last};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_EMPTY: begin
                // ready is low in the first cycle after reset, take nothing
                if (fetch_valid && fetch_ready) begin
                    next_state = ST_GROUP;
                end
            end
            ST_GROUP: begin
                if (first_heavy) begin
                    next_state = ST_PENALTY;
                end else begin
                    next_state = ST_EMIT;
                end
            end
            ST_PENALTY: begin
                if (pen_cnt == 2'h1) begin
                    next_state = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (push && cur_last) begin
                    if (emit_lane == 1'b0 && grp_mask[1]) begin
                        next_state = ST_EMIT;
                    end else if (emit_lane == 1'b0 && hold_pend[1]) begin
                        next_state = ST_GROUP;
                    end else begin
                        next_state = ST_EMPTY;
                    end
                end
            end
            default: next_state = ST_EMPTY;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= ST_EMPTY;
        end else begin
            state <= next_state;
        end
    end

    // fetch is held off until the whole packet has drained
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fetch_ready <= 1'b0;
        end else begin
            fetch_ready <= (next_state == ST_EMPTY);
        end
    end

    // ------------------------------------------------------------
    // packet capture and retirement of lanes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hold_pend <= '0;
        end else if (state == ST_EMPTY && fetch_valid && fetch_ready) begin
            hold_pend <= {lane1_valid, 1'b1};
        end else if (push && cur_last) begin
            hold_pend[emit_lane] <= 1'b0;
        end
    end

    // a memory call is a branch even if fetch did not mark it
    always_ff @(posedge sys_clk) begin
        if (state == ST_EMPTY && fetch_valid && fetch_ready) begin
            hold_len[0] <= inst0_length;
            hold_pfx[0] <= inst0_prefixes;
            hold_cls[0] <= inst_class_type'(inst0_class);
            hold_br[0]  <= inst0_branch ||
                           (inst_class_type'(inst0_class) == CLS_CALL_MEM);
            hold_len[1] <= inst1_length;
            hold_pfx[1] <= inst1_prefixes;
            hold_cls[1] <= inst_class_type'(inst1_class);
            hold_br[1]  <= inst1_branch ||
                           (inst_class_type'(inst1_class) == CLS_CALL_MEM);
        end
    end

    // ------------------------------------------------------------
    // group bookkeeping: lanes, slots and flow step
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            grp_mask  <= '0;
            emit_lane <= 1'b0;
            emit_slot <= 1'b0;
            step      <= STEP_RESET;
        end else if (state == ST_GROUP) begin
            grp_mask  <= first_lane ? 2'b10 : {join_second, 1'b1};
            emit_lane <= first_lane;
            emit_slot <= 1'b0;
            step      <= STEP_RESET;
        end else if (push) begin
            if (cur_last) begin
                // older lane first keeps program order
                emit_lane <= 1'b1;
                emit_slot <= 1'b1;
                step      <= STEP_RESET;
            end else begin
                step <= step + 2'h1;
            end
        end
    end

    // penalty counter runs exactly the stall length
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pen_cnt <= '0;
        end else if (state == ST_GROUP) begin
            pen_cnt <= PREFIX_PENALTY_CYCLES;
        end else if (state == ST_PENALTY) begin
            pen_cnt <= pen_cnt - 2'h1;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            penalty_active <= 1'b0;
            solo_decode    <= 1'b0;
        end else begin
            penalty_active <= (next_state == ST_PENALTY);
            if (state == ST_GROUP) begin
                solo_decode <= first_solo;
            end
        end
    end

    // ------------------------------------------------------------
    // output buffer; the backend may stall without losing a word
    // ------------------------------------------------------------
    uop_skid_buffer #(
        .WIDTH (UOP_W)
    ) u_buffer (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (uop_valid),
        .out_ready (uop_ready),
        .out_data  (buf_out_data)
    );

    assign uop_kind = buf_out_data[UOP_KIND_LSB +: 4];
    assign uop_slot = buf_out_data[UOP_SLOT_BIT];
    assign uop_rom  = buf_out_data[UOP_ROM_BIT];
    assign uop_last = buf_out_data[UOP_LAST_BIT];

endmodule
`default_nettype wire

// ### testbench/decode_throttle_asserts.sv
// port assertions for the decode throttle
`timescale 1ns/1ps
`default_nettype none
module decode_throttle_checker (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // fetch and uop sides
    input  wire logic       fetch_valid,
    input  wire logic       fetch_ready,
    input  wire logic       uop_valid,
    input  wire logic       uop_ready,
    input  wire logic [3:0] uop_kind,
    input  wire logic       uop_slot,
    input  wire logic       uop_rom,
    input  wire logic       uop_last,
    // status
    input  wire logic       penalty_active,
    input  wire logic       solo_decode
);
    logic [3:0] prev_kind;
    logic       prev_last;

    // ------------------------------------------------------------
    // helper: the word taken before, for flow order checks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prev_kind <= 4'h0;
            prev_last <= 1'b1;
        end else if (uop_valid && uop_ready) begin
            prev_kind <= uop_kind;
            prev_last <= uop_last;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_take_drops_ready: assert property (fetch_valid && fetch_ready |=> !fetch_ready)
        else $error("fetch_ready stayed high after a take");
    a_penalty_three: assert property ($rose(penalty_active) |-> penalty_active[*3] ##1 !penalty_active)
        else $error("prefix penalty is not three cycles");
    a_penalty_holds: assert property (penalty_active |-> !fetch_ready)
        else $error("fetch accepted during penalty");
    a_word_stands: assert property (uop_valid && !uop_ready |=> uop_valid && $stable({uop_kind, uop_slot, uop_rom, uop_last}))
        else $error("uop word changed while stalled");
    a_solo_slot_zero: assert property (solo_decode && uop_valid |-> !uop_slot)
        else $error("solo instruction left slot zero");
    a_rom_kinds: assert property (uop_valid && uop_rom |-> uop_kind inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7})
        else $error("rom flow with a direct kind");
    a_merge_after_alu: assert property (uop_valid && uop_ready && uop_kind == 4'h1 |-> prev_kind == 4'h0 && !prev_last && uop_last && !uop_rom)
        else $error("flag merge not after its alu uop");
    a_direct_multiply: assert property (uop_valid && uop_kind == 4'h8 |-> !uop_rom && uop_last)
        else $error("two operand multiply not direct");
    a_wide_high_ends: assert property (uop_valid && uop_kind == 4'h7 |-> uop_rom && uop_last && prev_kind == 4'h6)
        else $error("wide multiply flow out of shape");
endmodule
bind instruction_decode_throttle decode_throttle_checker chk (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .fetch_valid    (fetch_valid),
    .fetch_ready    (fetch_ready),
    .uop_valid      (uop_valid),
    .uop_ready      (uop_ready),
    .uop_kind       (uop_kind),
    .uop_slot       (uop_slot),
    .uop_rom        (uop_rom),
    .uop_last       (uop_last),
    .penalty_active (penalty_active),
    .solo_decode    (solo_decode)
);
`default_nettype wire

// ### testbench/uop_sink_model.sv
// backend model: takes uop words, promptly or one in three cycles
`timescale 1ns/1ps
`default_nettype none
module uop_sink_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // uop stream
    input  wire logic       uop_valid,
    output logic            uop_ready,
    input  wire logic [6:0] uop_word,
    // stall pattern select
    input  wire logic       slow
);
    logic [6:0] got[$];
    logic [1:0] phase;

    // slow mode takes one word in three, so the buffer fills up
    always_ff @(posedge sys_clk) begin
        if (!rstn)
            phase <= 2'h0;
        else
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end
    assign uop_ready = rstn && (!slow || phase == 2'h0);

    // capture every taken word in arrival order
    always @(posedge sys_clk) begin
        if (rstn && uop_valid && uop_ready)
            got.push_back(uop_word);
    end
endmodule
`default_nettype wire

// ### testbench/instruction_decode_throttle_tb.sv
// self-checking bench for the decode throttle
`timescale 1ns/1ps
`default_nettype none
module instruction_decode_throttle_tb;
    logic       sys_clk, rstn, fetch_valid, fetch_ready, lane1_valid;
    logic [3:0] inst0_length, inst0_prefixes, inst1_length, inst1_prefixes;
    logic       inst0_branch, inst1_branch, slow;
    logic [2:0] inst0_class, inst1_class;
    logic       uop_valid, uop_ready, uop_slot, uop_rom, uop_last;
    logic [3:0] uop_kind;
    logic       penalty_active, solo_decode;
    logic [6:0] exp_q[$];
    int         mismatches, tests_run, cycles, pen;

    instruction_decode_throttle dut (
        .sys_clk(sys_clk), .rstn(rstn),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .lane1_valid(lane1_valid),
        .inst0_length(inst0_length), .inst0_prefixes(inst0_prefixes),
        .inst0_branch(inst0_branch), .inst0_class(inst0_class),
        .inst1_length(inst1_length), .inst1_prefixes(inst1_prefixes),
        .inst1_branch(inst1_branch), .inst1_class(inst1_class),
        .uop_valid(uop_valid), .uop_ready(uop_ready), .uop_kind(uop_kind),
        .uop_slot(uop_slot), .uop_rom(uop_rom), .uop_last(uop_last),
        .penalty_active(penalty_active), .solo_decode(solo_decode));
    uop_sink_model sink (
        .sys_clk(sys_clk), .rstn(rstn), .uop_valid(uop_valid),
        .uop_ready(uop_ready), .slow(slow),
        .uop_word({uop_kind, uop_slot, uop_rom, uop_last}));

    // ------------------------------------------------------------
    // clock, hang guard and closing report
    // ------------------------------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_val(input logic [6:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // expected words {kind, slot, rom, last} of one instruction
    function automatic void add_flow(input logic [2:0] c, input logic b,
                                     input logic s);
        logic [3:0] k[$];
        logic       r;
        r = (c == 3'h2) || (c == 3'h3) || (c == 3'h4);
        case (c)
            3'h1: k = '{4'h0, 4'h1};
            3'h2: k = '{4'h2, 4'h3, 4'h4, 4'h5};
            3'h3: k = '{4'h2, 4'h3, 4'h4};
            3'h4: k = '{4'h6, 4'h7};
            3'h5: k = '{4'h8};
            default: k = '{b ? 4'h5 : 4'h0};
        endcase
        foreach (k[i])
            exp_q.push_back({k[i], s, r, i == k.size() - 1});
    endfunction

    // lane fields {length, prefixes, branch, class}; s1 is lane 1's slot
    task automatic run_pkt(input logic [11:0] a, input logic v1,
                           input logic [11:0] b, input logic s1,
                           input logic slw, output int pn);
        int n;
        exp_q.delete();
        sink.got.delete();
        pn = 0;
        add_flow(a[2:0], a[3], 1'b0);
        if (v1)
            add_flow(b[2:0], b[3], s1);
        @(negedge sys_clk);
        slow = slw;
        {inst0_length, inst0_prefixes, inst0_branch, inst0_class} = a;
        {inst1_length, inst1_prefixes, inst1_branch, inst1_class} = b;
        lane1_valid = v1;
        fetch_valid = 1'b1;
        n = 0;
        while (fetch_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        fetch_valid = 1'b0;
        n = 0;
        // wait until fetch reopens and every expected word came out
        while (n < 200 && !(fetch_ready === 1'b1 &&
               sink.got.size() == exp_q.size())) begin
            @(negedge sys_clk);
            if (penalty_active === 1'b1)
                pn++;
            n++;
        end
        check_val(7'(sink.got.size()), 7'(exp_q.size()), "uop count");
        foreach (exp_q[i])
            check_val(sink.got[i], exp_q[i], "uop word");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_pair_limit();
        run_pkt({4'h8, 4'h3, 1'b0, 3'h0}, 1, {4'h8, 4'h3, 1'b0, 3'h1}, 1, 0, pen);
        check_val(7'(pen), 7'h0, "no penalty at three");
    endtask

    task automatic t_long_solo();
        run_pkt({4'h9, 4'h0, 1'b0, 3'h0}, 1, {4'h4, 4'h0, 1'b0, 3'h5}, 0, 0, pen);
        run_pkt({4'h4, 4'h0, 1'b0, 3'h0}, 1, {4'hf, 4'h0, 1'b0, 3'h3}, 0, 0, pen);
        check_val(7'(solo_decode), 7'h1, "solo flag");
    endtask

    task automatic t_prefix();
        run_pkt({4'h5, 4'h4, 1'b0, 3'h1}, 1, {4'h3, 4'h0, 1'b0, 3'h0}, 0, 0, pen);
        check_val(7'(pen), 7'h3, "penalty cycles");
        run_pkt({4'h3, 4'h0, 1'b0, 3'h0}, 1, {4'h3, 4'h4, 1'b0, 3'h5}, 0, 0, pen);
        check_val(7'(pen), 7'h3, "penalty lane 1");
    endtask

    task automatic t_branches();
        run_pkt({4'h2, 4'h0, 1'b1, 3'h0}, 1, {4'h6, 4'h1, 1'b0, 3'h2}, 0, 0, pen);
        run_pkt({4'h2, 4'h0, 1'b1, 3'h0}, 1, {4'h2, 4'h0, 1'b1, 3'h0}, 0, 0, pen);
        run_pkt({4'h2, 4'h0, 1'b1, 3'h0}, 1, {4'h2, 4'h0, 1'b0, 3'h0}, 1, 0, pen);
    endtask

    // the backend stalls so the two-entry buffer fills and decode waits
    task automatic t_stall();
        run_pkt({4'h3, 4'h0, 1'b0, 3'h3}, 1, {4'h3, 4'h0, 1'b0, 3'h4}, 1, 1, pen);
        run_pkt({4'h4, 4'h0, 1'b0, 3'h5}, 0, {4'h4, 4'h0, 1'b0, 3'h0}, 0, 1, pen);
        run_pkt({4'h3, 4'h2, 1'b0, 3'h1}, 1, {4'h3, 4'h0, 1'b0, 3'h4}, 1, 1, pen);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        fetch_valid = 1'b0;
        lane1_valid = 1'b0;
        {inst0_length, inst0_prefixes, inst0_branch, inst0_class} = 12'h0;
        {inst1_length, inst1_prefixes, inst1_branch, inst1_class} = 12'h0;
        slow = 1'b0;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        t_pair_limit();
        t_long_solo();
        t_prefix();
        t_branches();
        t_stall();
        stop_test();
    end
endmodule
`default_nettype wire
